// >>> bench/fspc_core_model.sv
`timescale 1ns/1ns
// ---------------------------------------------------------------
// core issuing store and load instructions, plus flash array
// ---------------------------------------------------------------
module fspc_core_model (
  // clock
  input wire logic i_clk,
  // flash array read port
  input wire logic [14:0] i_flash_rd_addr,
  output logic [15:0] o_flash_rd_word,
  // instructions toward the controller
  output logic o_store_instr,
  output logic o_load_instr,
  output logic [15:0] o_pointer,
  output logic [15:0] o_data_word_pair
);
  // flash contents: fixed scramble of the word address
  assign o_flash_rd_word = {1'b1, i_flash_rd_addr} ^ 16'h3c5a;
  initial begin
    o_store_instr = 1'b0;
    o_load_instr = 1'b0;
    o_pointer = 16'h0000;
    o_data_word_pair = 16'h0000;
  end
  // one instruction; operands inverted after so stale values never help
  task automatic issue(input logic st, input logic [15:0] ptr, input logic [15:0] dat);
    @(posedge i_clk);
    o_store_instr <= st;
    o_load_instr <= !st;
    o_pointer <= ptr;
    o_data_word_pair <= dat;
    @(posedge i_clk);
    o_store_instr <= 1'b0;
    o_load_instr <= 1'b0;
    o_pointer <= ~ptr;
    o_data_word_pair <= ~dat;
  endtask
endmodule

// >>> bench/fspc_flash_self_prog_assertions.sv
`timescale 1ns/1ns
// ---------------------------------------------------------------
// port checker for the flash self-program controller
// ---------------------------------------------------------------
module fspc_sva_chk #(
  parameter logic [15:0] OP_CYCLES = 16'h0014
) (
  // clock, reset and register port
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [7:0] i_addr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  // core side
  input wire logic i_store_instr,
  input wire logic i_load_instr,
  input wire logic [15:0] i_pointer,
  input wire logic i_eeprom_write_busy,
  input wire logic o_core_halt,
  input wire logic o_load_valid,
  // flash side
  input wire logic [14:0] o_flash_rd_addr,
  input wire logic o_flash_erase,
  input wire logic o_flash_program,
  input wire logic o_lock_program,
  input wire logic [6:0] o_flash_page
);
  logic [15:0] run_cnt_reg;
  logic [6:0] ptr_page;
  assign ptr_page = i_pointer[12:6];
  // halt length counter, kept through reset since a started op finishes
  always_ff @(posedge i_clk) begin
    if (o_core_halt) begin
      run_cnt_reg <= run_cnt_reg + 16'h0001;
    end else begin
      run_cnt_reg <= 16'h0000;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  sequence s_hold; o_core_halt [*2]; endsequence
  property p_halt_src; o_core_halt == (o_flash_erase | o_flash_program | o_lock_program);
  endproperty
  property p_launch; $rose(o_core_halt) |-> $past(i_store_instr) and s_hold; endproperty
  property p_ee_block; $rose(o_core_halt) |-> !$past(i_eeprom_write_busy); endproperty
  property p_len; $fell(o_core_halt) |-> run_cnt_reg == OP_CYCLES; endproperty
  property p_page; $rose(o_flash_erase) || $rose(o_flash_program) |-> o_flash_page == $past(ptr_page);
  endproperty
  property p_addr; o_flash_rd_addr == i_pointer[15:1]; endproperty
  property p_load; i_load_instr |=> o_load_valid; endproperty
  property p_rd_idle; !i_rd |=> o_rdata == 8'h00; endproperty
  property p_rsvd; i_rd && i_addr == 8'h00 |=> o_rdata[7:6] == 2'b00; endproperty
  a_halt_src: assert property (p_halt_src) else $error("halt not tied to op");
  a_launch: assert property (p_launch) else $error("op start without store");
  a_ee_block: assert property (p_ee_block) else $error("op during eeprom write");
  a_len: assert property (p_len) else $error("op length wrong");
  a_page: assert property (p_page) else $error("op page wrong");
  a_addr: assert property (p_addr) else $error("flash address split wrong");
  a_load: assert property (p_load) else $error("load not answered");
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
endmodule

bind fspc_flash_self_prog fspc_sva_chk #(.OP_CYCLES(OP_CYCLES)) fspc_sva_chk_i (.i_clk, .i_srst,
  .i_addr, .i_rd, .o_rdata, .i_store_instr, .i_load_instr, .i_pointer, .i_eeprom_write_busy,
  .o_core_halt, .o_load_valid, .o_flash_rd_addr, .o_flash_erase, .o_flash_program,
  .o_lock_program, .o_flash_page);

// >>> bench/fspc_flash_self_prog_tb_top.sv
`timescale 1ns/1ns
// ---------------------------------------------------------------
// self-checking bench for the flash self-program controller
// ---------------------------------------------------------------
module fspc_flash_self_prog_tb_top;
  import fspc_pkg::*;
  localparam logic [15:0] OP = 16'h0014;
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_eeprom_write_busy = 1'b0;
  logic [7:0] i_fuse_low_prog = 8'h00;
  logic [7:0] i_fuse_high_prog = 8'h00;
  logic [7:0] i_lock_prog = 8'h00;
  logic [4:0] i_buf_rd_idx = 5'h00;
  logic i_store_instr, i_load_instr, o_core_halt, o_load_valid;
  logic o_flash_erase, o_flash_program, o_lock_program;
  logic [15:0] i_pointer, i_data_word_pair, i_flash_rd_word, o_buf_rd_word, dat;
  logic [7:0] o_rdata, o_load_data, o_lock_wr_data;
  logic [14:0] o_flash_rd_addr;
  logic [6:0] o_flash_page;
  logic rd_q = 1'b0;
  logic [7:0] exp_q[$];
  logic [31:0] seed = 32'h2066;
  int n_errors = 0;
  int n_compared = 0;

  always #50 i_clk = ~i_clk;

  fspc_flash_self_prog #(.OP_CYCLES(OP)) fspc_flash_self_prog_i (.i_clk, .i_srst, .i_addr,
    .i_wdata, .i_wr, .i_rd, .o_rdata, .i_store_instr, .i_load_instr, .i_pointer,
    .i_data_word_pair, .o_core_halt, .o_load_valid, .o_load_data, .i_eeprom_write_busy,
    .i_fuse_low_prog, .i_fuse_high_prog, .i_lock_prog, .o_flash_rd_addr, .i_flash_rd_word,
    .o_flash_erase, .o_flash_program, .o_lock_program, .o_flash_page, .o_lock_wr_data,
    .i_buf_rd_idx, .o_buf_rd_word);
  fspc_core_model core_i (.i_clk(i_clk), .i_flash_rd_addr(o_flash_rd_addr),
    .o_flash_rd_word(i_flash_rd_word), .o_store_instr(i_store_instr),
    .o_load_instr(i_load_instr), .o_pointer(i_pointer), .o_data_word_pair(i_data_word_pair));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // byte an ordinary load returns from the scrambled flash image
  function automatic logic [7:0] nrm(input logic [15:0] p);
    logic [15:0] w;
    w = {1'b1, p[15:1]} ^ 16'h3c5a;
    return p[0] ? w[15:8] : w[7:0];
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    if (n_errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // monitor: read data and load answers against the oldest note
  always @(posedge i_clk) begin
    rd_q <= i_rd;
    if (rd_q || o_load_valid) begin
      if (exp_q.size() == 0) begin
        n_errors++;
        $display("MISMATCH t=%0t unexpected result", $time);
      end else begin
        check({8'h00, rd_q ? o_rdata : o_load_data}, {8'h00, exp_q.pop_front()});
      end
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
  endtask
  task automatic ld(input logic [15:0] p, input logic [7:0] e);
    exp_q.push_back(e);
    core_i.issue(1'b0, p, 16'h0000);
  endtask
  task automatic buf_chk(input logic [4:0] idx, input logic [15:0] e);
    @(posedge i_clk);
    i_buf_rd_idx <= idx;
    @(posedge i_clk);
    #1;
    check(o_buf_rd_word, e);
  endtask
  // timed op; an optional one-cycle reset lands mid-run
  task automatic op(input logic [7:0] pat, input logic [15:0] ptr, input int rst_at);
    int n;
    n = 0;
    seed = xs(seed);
    wr(FSPC_CTRL_OFS, pat);
    core_i.issue(1'b1, ptr, seed[15:0]);
    #1;
    check({15'h0000, o_core_halt}, 16'h0001);
    if (pat == 8'(FSPC_PAT_FUSE)) begin
      check({8'h00, o_lock_wr_data}, {8'h00, seed[7:0]});
    end else begin
      check({9'h000, o_flash_page}, {9'h000, ptr[12:6]});
    end
    while (o_core_halt === 1'b1 && n < 999) begin
      @(posedge i_clk);
      i_srst <= (n == rst_at);
      n++;
      #1;
    end
    if (n >= 999) begin
      n_errors++;
      wrap_up();
    end
    check(16'(n), OP);
    rd(FSPC_CTRL_OFS, 8'h00);
  endtask

  initial begin
    repeat (20) @(posedge i_clk);
    i_srst <= 1'b0;
    i_fuse_low_prog <= seed[7:0];
    i_fuse_high_prog <= seed[15:8];
    i_lock_prog <= seed[23:16];
    rd(FSPC_CTRL_OFS, 8'h00);
    rd(FSPC_STAT_OFS, 8'h00);
    wr(8'h7e, 8'hff);
    rd(8'h7e, 8'h00);
    // refused patterns, random upper bits
    for (int k = 0; k < 32; k++) begin
      if (!(5'(k) inside {FSPC_PAT_CLEAR, FSPC_PAT_FUSE, FSPC_PAT_WRITE, FSPC_PAT_ERASE,
          FSPC_PAT_LOAD})) begin
        seed = xs(seed);
        wr(FSPC_CTRL_OFS, {seed[7:5], 5'(k)});
        rd(FSPC_CTRL_OFS, 8'h00);
      end
    end
    seed = xs(seed);
    dat = seed[15:0];
    wr(FSPC_CTRL_OFS, 8'(FSPC_PAT_LOAD));
    core_i.issue(1'b1, 16'h0047, dat);
    buf_chk(5'd3, dat);
    buf_chk(5'd2, FSPC_ERASED_WORD);
    wr(FSPC_CTRL_OFS, 8'(FSPC_PAT_CLEAR));
    buf_chk(5'd3, FSPC_ERASED_WORD);
    // clear arming keeps its store window; a new arming once it lapses is accepted
    repeat (2) @(posedge i_clk);
    wr(FSPC_CTRL_OFS, 8'(FSPC_PAT_FUSE));
    ld(FSPC_PTR_FUSE_LOW, ~i_fuse_low_prog);
    wr(FSPC_CTRL_OFS, 8'(FSPC_PAT_FUSE));
    ld(FSPC_PTR_LOCK, ~i_lock_prog);
    wr(FSPC_CTRL_OFS, 8'(FSPC_PAT_FUSE));
    ld(FSPC_PTR_FUSE_HIGH, ~i_fuse_high_prog);
    rd(FSPC_CTRL_OFS, 8'h00);
    wr(FSPC_CTRL_OFS, 8'(FSPC_PAT_FUSE));
    repeat (4) @(posedge i_clk);
    ld(FSPC_PTR_LOCK, nrm(FSPC_PTR_LOCK));
    ld(16'h0123, nrm(16'h0123));
    wr(FSPC_CTRL_OFS, 8'h21);
    ld(16'h0002, FSPC_SIG_BYTE1);
    wr(FSPC_CTRL_OFS, 8'h21);
    core_i.issue(1'b1, 16'h0040, dat);
    #1;
    check({15'h0000, o_core_halt}, 16'h0000);
    wr(FSPC_CTRL_OFS, 8'(FSPC_PAT_ERASE));
    repeat (4) @(posedge i_clk);
    core_i.issue(1'b1, 16'h0040, dat);
    #1;
    check({15'h0000, o_core_halt}, 16'h0000);
    // eeprom write mid-fill: buffer lost, arming refused
    wr(FSPC_CTRL_OFS, 8'(FSPC_PAT_LOAD));
    core_i.issue(1'b1, 16'h0004, dat);
    @(posedge i_clk);
    i_eeprom_write_busy <= 1'b1;
    wr(FSPC_CTRL_OFS, 8'(FSPC_PAT_FUSE));
    ld(FSPC_PTR_FUSE_LOW, nrm(FSPC_PTR_FUSE_LOW));
    @(posedge i_clk);
    i_eeprom_write_busy <= 1'b0;
    buf_chk(5'd2, FSPC_ERASED_WORD);
    op(8'(FSPC_PAT_ERASE), 16'h0140, -1);
    op(8'(FSPC_PAT_FUSE), 16'h0001, -1);
    wr(FSPC_CTRL_OFS, 8'(FSPC_PAT_LOAD));
    core_i.issue(1'b1, 16'h000e, dat);
    op(8'(FSPC_PAT_WRITE), 16'h0080, 4);
    buf_chk(5'd7, FSPC_ERASED_WORD);
    repeat (4) @(posedge i_clk);
    check(16'(exp_q.size()), 16'h0000);
    wrap_up();
  end
endmodule

// >>> verilog/fspc_flash_self_prog.sv
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/1ns
module fspc_flash_self_prog #(
  parameter logic [15:0] OP_CYCLES = fspc_pkg::FSPC_OP_MIN_CYCLES
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // register port
  input wire logic [fspc_pkg::FSPC_ADDR_W-1:0] i_addr,
  input wire logic [fspc_pkg::FSPC_DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [fspc_pkg::FSPC_DATA_W-1:0] o_rdata,
  // core instruction side
  input wire logic i_store_instr,
  input wire logic i_load_instr,
  input wire logic [15:0] i_pointer,
  input wire logic [15:0] i_data_word_pair,
  output logic o_core_halt,
  output logic o_load_valid,
  output logic [7:0] o_load_data,
  // eeprom status
  input wire logic i_eeprom_write_busy,
  // fuse and lock values, one marks a programmed bit
  input wire logic [7:0] i_fuse_low_prog,
  input wire logic [7:0] i_fuse_high_prog,
  input wire logic [7:0] i_lock_prog,
  // flash array side
  output logic [14:0] o_flash_rd_addr,
  input wire logic [15:0] i_flash_rd_word,
  output logic o_flash_erase,
  output logic o_flash_program,
  output logic o_lock_program,
  output logic [fspc_pkg::FSPC_PAGE_W-1:0] o_flash_page,
  output logic [7:0] o_lock_wr_data,
  input wire logic [fspc_pkg::FSPC_WORD_W-1:0] i_buf_rd_idx,
  output logic [15:0] o_buf_rd_word
);
  import fspc_pkg::*;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [5:0] flags_reg;
  logic [5:0] flags_next;
  fspc_state_t state_reg;
  logic [15:0] op_cnt_reg;
  logic [15:0] page_buf [FSPC_PAGE_WORDS];
  logic buf_filled_reg;
  logic ee_busy_d_reg;
  logic store_open;
  logic load_open;
  logic op_busy;
  logic op_done;
  logic wr_ctrl;
  logic pattern_ok;
  logic arm_accept;
  logic armed;
  logic mode_load;
  logic mode_erase;
  logic mode_write;
  logic mode_fuse;
  logic mode_clear;
  logic mode_sig;
  logic store_hit;
  logic load_hit;
  logic window_lapse;
  logic ee_start;
  logic buf_erase;
  logic [4:0] wr_low;
  logic [FSPC_WORD_W-1:0] word_idx;
  logic [FSPC_PAGE_W-1:0] page_idx;
  logic [7:0] special_byte;

  // ---------------------------------------------------------------
  // pointer split and arming decode
  // ---------------------------------------------------------------
  // word within page and page select
  assign word_idx = i_pointer[FSPC_WORD_LSB +: FSPC_WORD_W];
  assign page_idx = i_pointer[FSPC_PAGE_LSB +: FSPC_PAGE_W];
  assign o_flash_rd_addr = i_pointer[15:1];

  assign wr_low = i_wdata[4:0];
  assign wr_ctrl = i_wr && (i_addr == FSPC_CTRL_OFS);

  // signature read only combines with plain store enable
  always_comb begin
    case (wr_low)
      FSPC_PAT_LOAD: pattern_ok = 1'b1;
      FSPC_PAT_CLEAR,
      FSPC_PAT_FUSE,
      FSPC_PAT_WRITE,
      FSPC_PAT_ERASE: pattern_ok = !i_wdata[FSPC_SIG_READ_BIT];
      default: pattern_ok = 1'b0;
    endcase
  end

  // a second arming is refused while one is pending or running
  assign armed = flags_reg[FSPC_STORE_EN_BIT];
  assign op_busy = (state_reg != FSPC_S_IDLE);
  assign arm_accept = wr_ctrl && pattern_ok && !armed && !op_busy
    && !i_eeprom_write_busy;

  // mode decode of the armed pattern
  assign mode_sig = armed && flags_reg[FSPC_SIG_READ_BIT];
  assign mode_load = armed && (flags_reg[4:0] == FSPC_PAT_LOAD) && !mode_sig;
  assign mode_erase = armed && (flags_reg[4:0] == FSPC_PAT_ERASE);
  assign mode_write = armed && (flags_reg[4:0] == FSPC_PAT_WRITE);
  assign mode_fuse = armed && (flags_reg[4:0] == FSPC_PAT_FUSE);
  assign mode_clear = armed && (flags_reg[4:0] == FSPC_PAT_CLEAR);

  // ---------------------------------------------------------------
  // arming windows
  // ---------------------------------------------------------------
  fspc_window_timer #(
    .LEN(FSPC_STORE_WIN)
  ) u_store_win (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_start(arm_accept),
    .i_stop(store_hit),
    .o_open(store_open)
  );

  fspc_window_timer #(
    .LEN(FSPC_LOAD_WIN)
  ) u_load_win (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_start(arm_accept),
    .i_stop(load_hit),
    .o_open(load_open)
  );

  // instructions only count inside their window and with eeprom idle
  assign store_hit = i_store_instr && armed && store_open && !op_busy
    && !i_eeprom_write_busy;
  assign load_hit = i_load_instr && load_open && (mode_fuse || mode_sig)
    && !i_eeprom_write_busy;

  // lapse: store window gone, or load window gone for read modes
  assign window_lapse = armed && !op_busy
    && (!store_open || ((mode_fuse || mode_sig) && !load_open));

  // ---------------------------------------------------------------
  // control flags
  // ---------------------------------------------------------------
  // flags next value; running erase, write or lock write keeps them up
  always_comb begin
    flags_next = flags_reg;
    if (arm_accept) begin
      flags_next = i_wdata[5:0];
    end else if (op_busy) begin
      if (op_done) begin
        flags_next = FSPC_CTRL_RESET;
      end else begin
        flags_next = flags_reg;
      end
    end else if (store_hit && (mode_erase || mode_write || mode_fuse)) begin
      flags_next = flags_reg; // held while the timed operation runs
    end else if (store_hit || load_hit || window_lapse) begin
      flags_next = FSPC_CTRL_RESET;
    end
  end

  // flags register; reset leaves a running operation's flags alone
  always_ff @(posedge i_clk) begin
    if (i_srst && !op_busy) begin
      flags_reg <= FSPC_CTRL_RESET;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // ---------------------------------------------------------------
  // timed flash operation
  // ---------------------------------------------------------------
  assign op_done = op_busy && (op_cnt_reg == 16'h0001);

  // state survives reset while erase, write or lock write runs
  always_ff @(posedge i_clk) begin
    case (state_reg)
      FSPC_S_ERASE,
      FSPC_S_WRITE,
      FSPC_S_LOCK: begin
        if (op_done) begin
          state_reg <= FSPC_S_IDLE;
        end
      end
      FSPC_S_IDLE: begin
        if (i_srst) begin
          state_reg <= FSPC_S_IDLE;
        end else if (store_hit && mode_erase) begin
          state_reg <= FSPC_S_ERASE;
        end else if (store_hit && mode_write) begin
          state_reg <= FSPC_S_WRITE;
        end else if (store_hit && mode_fuse) begin
          state_reg <= FSPC_S_LOCK;
        end
      end
      default: state_reg <= FSPC_S_IDLE;
    endcase
  end

  // operation length counter, counts down to zero; the op ends at one
  always_ff @(posedge i_clk) begin
    if (i_srst && !op_busy) begin
      op_cnt_reg <= 16'h0000;
    end else if (store_hit && !op_busy && (mode_erase || mode_write || mode_fuse)) begin
      op_cnt_reg <= OP_CYCLES;
    end else if (op_busy && (op_cnt_reg != 16'h0000)) begin
      op_cnt_reg <= op_cnt_reg - 16'h0001;
    end
  end

  // target page and lock data latched at the store
  always_ff @(posedge i_clk) begin
    if (i_srst && !op_busy) begin
      o_flash_page <= '0;
      o_lock_wr_data <= 8'hff;
    end else if (store_hit && !op_busy) begin
      o_flash_page <= page_idx;
      o_lock_wr_data <= i_data_word_pair[7:0];
    end
  end

  // flash strobes are levels for the whole operation
  assign o_flash_erase = (state_reg == FSPC_S_ERASE);
  assign o_flash_program = (state_reg == FSPC_S_WRITE);
  assign o_lock_program = (state_reg == FSPC_S_LOCK);
  // the core is held for the whole timed operation
  assign o_core_halt = op_busy;

  // ---------------------------------------------------------------
  // temporary page buffer
  // ---------------------------------------------------------------
  // eeprom write starting mid fill loses the loaded data
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ee_busy_d_reg <= 1'b0;
    end else begin
      ee_busy_d_reg <= i_eeprom_write_busy;
    end
  end

  assign ee_start = i_eeprom_write_busy && !ee_busy_d_reg;
  // a reset during a write waits until the flash has taken the data
  assign buf_erase = (i_srst && !o_flash_program)
    || (arm_accept && (wr_low == FSPC_PAT_CLEAR))
    || (ee_start && buf_filled_reg)
    || (op_done && o_flash_program);

  // buffer words; erased value is all ones like erased flash
  always_ff @(posedge i_clk) begin
    if (buf_erase) begin
      for (int i = 0; i < FSPC_PAGE_WORDS; i++) begin
        page_buf[i] <= FSPC_ERASED_WORD;
      end
    end else if (store_hit && mode_load) begin
      page_buf[word_idx] <= i_data_word_pair;
    end
  end

  // fill marker for status and discard on eeprom start
  always_ff @(posedge i_clk) begin
    if (buf_erase) begin
      buf_filled_reg <= 1'b0;
    end else if (store_hit && mode_load) begin
      buf_filled_reg <= 1'b1;
    end
  end

  // flash side read of the buffer during page write
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_buf_rd_word <= FSPC_ERASED_WORD;
    end else begin
      o_buf_rd_word <= page_buf[i_buf_rd_idx];
    end
  end

  // ---------------------------------------------------------------
  // load instruction answer
  // ---------------------------------------------------------------
  // fuse, lock and signature bytes; programmed bits read as zero
  always_comb begin
    special_byte = FSPC_UNUSED_BYTE;
    if (mode_fuse) begin
      case (i_pointer)
        FSPC_PTR_FUSE_LOW: special_byte = ~i_fuse_low_prog;
        FSPC_PTR_LOCK: special_byte = ~i_lock_prog;
        FSPC_PTR_FUSE_HIGH: special_byte = ~i_fuse_high_prog;
        default: special_byte = FSPC_UNUSED_BYTE;
      endcase
    end else begin
      case (i_pointer[2:1])
        2'h0: special_byte = FSPC_SIG_BYTE0;
        2'h1: special_byte = FSPC_SIG_BYTE1;
        2'h2: special_byte = FSPC_SIG_BYTE2;
        default: special_byte = FSPC_UNUSED_BYTE;
      endcase
    end
  end

  // every load answers one cycle later; plain loads pick a flash byte
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_load_valid <= 1'b0;
      o_load_data <= 8'h00;
    end else begin
      o_load_valid <= i_load_instr;
      if (load_hit) begin
        o_load_data <= special_byte;
      end else if (i_load_instr) begin
        o_load_data <= i_pointer[0] ? i_flash_rd_word[15:8]
          : i_flash_rd_word[7:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // register read port
  // ---------------------------------------------------------------
  // data stand only in the cycle after the strobe
  always_ff @(posedge i_clk) begin
    if (i_srst || !i_rd) begin
      o_rdata <= 8'h00;
    end else begin
      case (i_addr)
        FSPC_CTRL_OFS: o_rdata <= {2'b00, flags_reg};
        FSPC_STAT_OFS: begin
          o_rdata <= 8'h00;
          o_rdata[FSPC_STAT_BUSY_BIT] <= op_busy;
          o_rdata[FSPC_STAT_FILLED_BIT] <= buf_filled_reg;
          o_rdata[FSPC_STAT_ARMED_BIT] <= armed;
        end
        default: o_rdata <= 8'h00;
      endcase
    end
  end

endmodule

// >>> verilog/fspc_pkg.sv
// ---------------------------------------------------------------
// flash self-program control constants
// ---------------------------------------------------------------
package fspc_pkg;

  // register port geometry
  localparam int FSPC_ADDR_W = 8;
  localparam int FSPC_DATA_W = 8;

  // register offsets
  localparam logic [7:0] FSPC_CTRL_OFS = 8'h00;
  localparam logic [7:0] FSPC_STAT_OFS = 8'h01;

  // control register field positions
  localparam int FSPC_SIG_READ_BIT = 5;
  localparam int FSPC_CLR_BUF_BIT = 4;
  localparam int FSPC_FUSE_READ_BIT = 3;
  localparam int FSPC_PG_WRITE_BIT = 2;
  localparam int FSPC_PG_ERASE_BIT = 1;
  localparam int FSPC_STORE_EN_BIT = 0;
  localparam logic [5:0] FSPC_CTRL_RESET = 6'h00;

  // status register field positions
  localparam int FSPC_STAT_BUSY_BIT = 0;
  localparam int FSPC_STAT_FILLED_BIT = 1;
  localparam int FSPC_STAT_ARMED_BIT = 2;

  // accepted low five bit patterns
  localparam logic [4:0] FSPC_PAT_CLEAR = 5'h11;
  localparam logic [4:0] FSPC_PAT_FUSE = 5'h09;
  localparam logic [4:0] FSPC_PAT_WRITE = 5'h05;
  localparam logic [4:0] FSPC_PAT_ERASE = 5'h03;
  localparam logic [4:0] FSPC_PAT_LOAD = 5'h01;

  // pointer layout: word in page, then page
  localparam int FSPC_WORD_LSB = 1;
  localparam int FSPC_WORD_W = 5;
  localparam int FSPC_PAGE_LSB = 6;
  localparam int FSPC_PAGE_W = 7;
  localparam int FSPC_PAGE_WORDS = 32;

  // fuse and lock pointer values
  localparam logic [15:0] FSPC_PTR_FUSE_LOW = 16'h0000;
  localparam logic [15:0] FSPC_PTR_LOCK = 16'h0001;
  localparam logic [15:0] FSPC_PTR_FUSE_HIGH = 16'h0003;

  // signature row contents, values arbitrary
  localparam logic [7:0] FSPC_SIG_BYTE0 = 8'h5a;
  localparam logic [7:0] FSPC_SIG_BYTE1 = 8'h3c;
  localparam logic [7:0] FSPC_SIG_BYTE2 = 8'h11;
  localparam logic [7:0] FSPC_UNUSED_BYTE = 8'hff;
  localparam logic [15:0] FSPC_ERASED_WORD = 16'hffff;

  // arming windows in clock cycles
  localparam logic [2:0] FSPC_STORE_WIN = 3'h4;
  localparam logic [2:0] FSPC_LOAD_WIN = 3'h3;

  // timed operation length
  localparam int FSPC_CLK_NS = 100;
  localparam int FSPC_OP_MIN_NS = 3700000;
  localparam int FSPC_OP_MAX_NS = 4500000;
  localparam logic [15:0] FSPC_OP_MIN_CYCLES =
    16'((FSPC_OP_MIN_NS + FSPC_CLK_NS - 1) / FSPC_CLK_NS);
  localparam logic [15:0] FSPC_OP_MAX_CYCLES = 16'(FSPC_OP_MAX_NS / FSPC_CLK_NS);

  // timed operation states
  typedef enum logic [3:0] {
    FSPC_S_IDLE = 4'b0001,
    FSPC_S_ERASE = 4'b0010,
    FSPC_S_WRITE = 4'b0100,
    FSPC_S_LOCK = 4'b1000
  } fspc_state_t;

endpackage

// >>> verilog/fspc_window_timer.sv
`timescale 1ns/1ns
// ---------------------------------------------------------------
// arming window: open for LEN cycles after the start pulse
// ---------------------------------------------------------------
module fspc_window_timer #(
  parameter logic [2:0] LEN = 3'h4
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // control
  input wire logic i_start,
  input wire logic i_stop,
  // state
  output logic o_open
);

  logic [2:0] cnt_reg;

  // down counter; start wins over stop
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cnt_reg <= 3'h0;
    end else if (i_start) begin
      cnt_reg <= LEN;
    end else if (i_stop) begin
      cnt_reg <= 3'h0;
    end else if (cnt_reg != 3'h0) begin
      cnt_reg <= cnt_reg - 3'h1;
    end
  end

  assign o_open = (cnt_reg != 3'h0);

endmodule
